// ---- include/fsm_pkg.sv ----
package fsm_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_ERRCODE = 8'h08;
    localparam logic [7:0] REG_LINKOK = 8'h0c;
    localparam logic [7:0] REG_PFACK = 8'h10;

    // ctrl fields
    localparam int CTRL_TMO_DIS = 0;
    localparam int CTRL_CONFIGURED = 1;
    localparam int CTRL_THREE_WORDS = 2;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // ****************************************
    // codes and timing
    // ****************************************
    localparam logic [15:0] SYS_ERR_CODE = 16'h005b;
    localparam logic [15:0] SHORT_OUT_CODE = 16'h0053;
    localparam logic [15:0] ZERO_WORD = 16'h0000;
    localparam int CLK_HZ = 100_000_000;
    localparam int BLINK_PERIOD_MS = 1000;
    localparam int BLINK_HALF_CYC = (CLK_HZ / 1000) * BLINK_PERIOD_MS / 2;

    typedef struct packed {
        logic remote_check_led;
        logic bus_active_led;
        logic remote_disable_led;
        logic param_exchange_led;
        logic system_fault_led;
    } fsm_leds_t;

    typedef enum logic [2:0] {
        FSM_RUN = 3'b001,
        FSM_NODATA = 3'b010,
        FSM_ERROR = 3'b100
    } fsm_state_t;

endpackage

// ---- verilog/fsm_monitor.sv ----
`timescale 1ns/1ps
module fsm_monitor
    import fsm_pkg::*;
#(
    parameter int N_DRIVES = 4,
    parameter int BLINK_HALF = BLINK_HALF_CYC
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // apb slave
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [7:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    // fieldbus side status pins
    input wire logic remote_in_ok_i,
    input wire logic bus_running_i,
    input wire logic cyclic_data_i,
    input wire logic out_seg_off_i,
    input wire logic param_traffic_i,
    input wire logic fieldbus_timeout_i,
    input wire logic hw_defect_i,
    input wire logic short_out_i,
    input wire logic maint_switch_on_i,
    // process data from master
    input wire logic [N_DRIVES*48-1:0] pout_data_i,
    input wire logic [7:0] dout_i,
    // drive side
    input wire logic [N_DRIVES-1:0] drive_alive_i,
    input wire logic [N_DRIVES*16-1:0] drive_stat1_i,
    input wire logic [7:0] hw_err_detail_i,
    input wire logic read_system_error_cmd_i,
    output logic [N_DRIVES*48-1:0] pout_data_o,
    output logic [7:0] dout_o,
    output logic [N_DRIVES*16-1:0] pin_stat1_o,
    output logic [N_DRIVES-1:0] drive_inhibit_o,
    output logic [7:0] sys_err_rd_o,
    output logic periph_fault_o,
    // indicators
    output fsm_leds_t leds_o
);

    // ****************************************
    // input synchronisers
    // ****************************************
    localparam int NS = 10;
    logic [NS-1:0] s1, s2;
    logic [N_DRIVES-1:0] a1, a2;
    logic rin, brun, cyc, oseg, ptr, fto, hwd, sho, mnt, rdc;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            s1 <= '0;
            s2 <= '0;
            a1 <= '0;
            a2 <= '0;
        end else begin
            s1 <= {read_system_error_cmd_i, maint_switch_on_i, short_out_i, hw_defect_i,
                   fieldbus_timeout_i, param_traffic_i, out_seg_off_i, cyclic_data_i,
                   bus_running_i, remote_in_ok_i};
            s2 <= s1;
            a1 <= drive_alive_i;
            a2 <= a1;
        end
    end
    assign {rdc, mnt, sho, hwd, fto, ptr, oseg, cyc, brun, rin} = s2;

    // ****************************************
    // registers
    // ****************************************
    logic [31:0] ctrl;
    logic pf_flag;
    logic [7:0] err_detail;
    logic [N_DRIVES-1:0] timed_out;
    logic blink;
    fsm_state_t state, next_state;

    function automatic logic [31:0] rd_mux(input logic [7:0] a, input logic [31:0] st,
                                           input logic [31:0] c, input logic [7:0] e,
                                           input logic [N_DRIVES-1:0] ok);
        logic [31:0] r;
        r = 32'h0000_0000;
        case (a)
            REG_CTRL: r = c;
            REG_STATUS: r = st;
            REG_ERRCODE: r = {24'h000000, e};
            REG_LINKOK: r = 32'(ok);
            REG_PFACK: r = 32'h0000_0000;
            default: r = 32'h0000_0000;
        endcase
        return r;
    endfunction

    function automatic logic addr_ok(input logic [7:0] a);
        return a == REG_CTRL || a == REG_STATUS || a == REG_ERRCODE || a == REG_LINKOK ||
               a == REG_PFACK;
    endfunction

    logic acc, wr;
    assign acc = psel_i && penable_i;
    assign wr = acc && pwrite_i && addr_ok(paddr_i);
    assign pready_o = 1'b1;
    assign pslverr_o = acc && !addr_ok(paddr_i);

    logic [31:0] status_word;
    assign status_word = {24'h000000, 1'b0, pf_flag, state == FSM_ERROR,
                          state == FSM_NODATA, |timed_out, hwd, fto, rin};

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctrl <= CTRL_RESET;
        end else if (wr && paddr_i == REG_CTRL) begin
            ctrl <= pwdata_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (psel_i && !penable_i && !pwrite_i) begin
            prdata_o <= rd_mux(paddr_i, status_word, ctrl, err_detail, ~timed_out);
        end
    end

    // peripheral fault: set wins over acknowledge
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            pf_flag <= 1'b0;
        end else if (sho) begin
            pf_flag <= 1'b1;
        end else if (wr && paddr_i == REG_PFACK && pwdata_i[0]) begin
            pf_flag <= 1'b0;
        end
    end
    assign periph_fault_o = pf_flag;

    // detail code loaded every cycle while defect present and held after it clears, readable by the control program
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            err_detail <= 8'h00;
            sys_err_rd_o <= 8'h00;
        end else begin
            if (hwd) begin
                err_detail <= hw_err_detail_i;
            end
            if (rdc) begin
                sys_err_rd_o <= err_detail;
            end
        end
    end

    // ****************************************
    // blink divider
    // ****************************************
    logic [31:0] bcnt;
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            bcnt <= 32'h0000_0000;
            blink <= 1'b0;
        end else if (bcnt == 32'(BLINK_HALF - 1)) begin
            bcnt <= 32'h0000_0000;
            blink <= !blink;
        end else begin
            bcnt <= bcnt + 32'h0000_0001;
        end
    end

    // ****************************************
    // drive link state
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            timed_out <= '0;
        end else begin
            timed_out <= ~a2;
        end
    end

    always_comb begin
        next_state = FSM_RUN;
        if (hwd) begin
            next_state = FSM_ERROR;
        end else if (!ctrl[CTRL_CONFIGURED] || !mnt || &timed_out) begin
            next_state = FSM_NODATA;
        end else if (|timed_out) begin
            next_state = FSM_ERROR;
        end
    end

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            state <= FSM_RUN;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************
    // process data path
    // ****************************************
    logic zero_out;
    assign zero_out = fto && !ctrl[CTRL_TMO_DIS];

    genvar g;
    generate
        for (g = 0; g < N_DRIVES; g++) begin : g_drv
            always_ff @(posedge ref_clk_i or negedge nrst_i) begin
                if (!nrst_i) begin
                    pout_data_o[g*48 +: 48] <= '0;
                    pin_stat1_o[g*16 +: 16] <= ZERO_WORD;
                    drive_inhibit_o[g] <= 1'b0;
                end else begin
                    if (zero_out || hwd) begin
                        // third word is ramp time; zero gives rapid stop
                        pout_data_o[g*48 +: 48] <= {ZERO_WORD, ZERO_WORD, ZERO_WORD};
                    end else if (!ctrl[CTRL_THREE_WORDS]) begin
                        pout_data_o[g*48 +: 48] <= {ZERO_WORD, pout_data_i[g*48 +: 32]};
                    end else begin
                        pout_data_o[g*48 +: 48] <= pout_data_i[g*48 +: 48];
                    end
                    if (hwd || timed_out[g]) begin
                        pin_stat1_o[g*16 +: 16] <= SYS_ERR_CODE;
                    end else if (sho) begin
                        pin_stat1_o[g*16 +: 16] <= SHORT_OUT_CODE;
                    end else begin
                        pin_stat1_o[g*16 +: 16] <= drive_stat1_i[g*16 +: 16];
                    end
                    drive_inhibit_o[g] <= hwd;
                end
            end
        end
    endgenerate

    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dout_o <= 8'h00;
        end else begin
            dout_o <= (zero_out || hwd) ? 8'h00 : dout_i;
        end
    end

    // ****************************************
    // indicators
    // ****************************************
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        if (!nrst_i) begin
            leds_o <= '0;
        end else begin
            leds_o.remote_check_led <= rin;
            leds_o.bus_active_led <= brun && (cyc || blink);
            leds_o.remote_disable_led <= oseg;
            leds_o.param_exchange_led <= ptr;
            unique case (state)
                FSM_RUN: leds_o.system_fault_led <= 1'b0;
                FSM_NODATA: leds_o.system_fault_led <= 1'b1;
                FSM_ERROR: leds_o.system_fault_led <= blink;
                default: leds_o.system_fault_led <= 1'b1;
            endcase
        end
    end

    // ****************************************
    // checks
    // ****************************************
    default clocking @(posedge ref_clk_i); endclocking
    default disable iff (!nrst_i);

    zero_out_a: assert property (zero_out |=> pout_data_o == '0 && dout_o == 8'h00)
        else $error("outputs not zeroed on timeout");
    ramp_zero_a: assert property (zero_out && ctrl[CTRL_THREE_WORDS] |=>
                                  pout_data_o[47:32] == 16'h0000)
        else $error("ramp word not zero");
    resume_a: assert property (!fto && !hwd && ctrl[CTRL_THREE_WORDS] |=>
                               pout_data_o == $past(pout_data_i))
        else $error("live data not forwarded");
    tmo_dis_a: assert property (fto && ctrl[CTRL_TMO_DIS] && !hwd && ctrl[CTRL_THREE_WORDS]
                                |=> pout_data_o == $past(pout_data_i))
        else $error("zeroing not disabled");
    err_code_a: assert property (hwd |=> pin_stat1_o[15:0] == SYS_ERR_CODE)
        else $error("code 91 missing");
    inhibit_a: assert property (hwd |=> &drive_inhibit_o)
        else $error("drives not inhibited");
    rc_led_a: assert property (1'b1 |=> leds_o.remote_check_led == $past(rin))
        else $error("remote check led wrong");
    err_flash_a: assert property (state == FSM_ERROR |=>
                                  leds_o.system_fault_led == $past(blink))
        else $error("error not flashing");
    nodata_a: assert property (state == FSM_NODATA |=> leds_o.system_fault_led)
        else $error("no-data led not steady");
    pf_set_a: assert property (sho |=> pf_flag)
        else $error("peripheral fault lost");

    tmo_c: cover property (zero_out ##1 !fto);
    hw_c: cover property (state == FSM_ERROR && hwd);
    part_c: cover property (|timed_out && !(&timed_out));

endmodule

// ---- dv/fsm_drive_model.sv ----
`timescale 1ns/1ps
// ****
// drive units on the rs-485 link
// ****
module fsm_drive_model
    import fsm_pkg::*;
#(
    parameter int N_DRIVES = 4,
    parameter int STOP_CYC = 20
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic nrst_i,
    // link side
    input wire logic [N_DRIVES-1:0] answer_i,
    output logic [N_DRIVES-1:0] drive_alive_o,
    output logic [N_DRIVES*16-1:0] drive_stat1_o,
    output logic [N_DRIVES-1:0] stopped_o
);
    int quiet [N_DRIVES];
    // a silent drive stops on its own; stop time shortened for simulation
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
        for (int g = 0; g < N_DRIVES; g++) begin
            if (!nrst_i) begin
                quiet[g] <= 0;
                stopped_o[g] <= 1'b0;
            end else if (answer_i[g]) begin
                quiet[g] <= 0;
                stopped_o[g] <= 1'b0;
            end else if (quiet[g] < STOP_CYC) begin
                quiet[g] <= quiet[g] + 1;
            end else begin
                stopped_o[g] <= 1'b1;
            end
        end
    end
    // a drive that does not answer leaves junk, not its last word, on the line
    always_comb begin
        drive_alive_o = answer_i;
        for (int g = 0; g < N_DRIVES; g++) begin
            drive_stat1_o[g*16+:16] = answer_i[g] ? 16'h0a00 + 16'(g) : ~(16'h0a00 + 16'(g));
        end
    end
endmodule

// ---- dv/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import fsm_pkg::*;
    // ****
    // bench signals
    // ****
    logic ref_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, err, rd_cmd = 1'b0, pready, pslverr, pf;
    logic [7:0] paddr = 8'h00, dout = 8'h00, detail = 8'h00, dout_q, sysrd;
    logic [31:0] pwdata = 32'h0000_0000, rd, prdata;
    // {rin, run, cyc, seg, par, fto, hwd, short, maint}
    logic [8:0] pin = 9'h000;
    logic [3:0] answer = 4'hf, alive, inh, stop;
    logic [63:0] stat1, pstat;
    logic [191:0] pd = '0, pout;
    fsm_leds_t leds;
    int n_errors = 0;
    int comparisons = 0;
    int c;
    int pb [3] = '{8, 5, 4};
    int lb [3] = '{4, 2, 1};
    localparam logic [191:0] P3 = {4{16'h3333, 16'h2222, 16'h1111}};
    localparam logic [191:0] P2 = {4{16'h0000, 16'h2222, 16'h1111}};

    fsm_monitor #(.N_DRIVES(4), .BLINK_HALF(4)) dut (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel), .penable_i(penable),
        .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(pslverr), .remote_in_ok_i(pin[8]),
        .bus_running_i(pin[7]), .cyclic_data_i(pin[6]), .out_seg_off_i(pin[5]),
        .param_traffic_i(pin[4]), .fieldbus_timeout_i(pin[3]), .hw_defect_i(pin[2]),
        .short_out_i(pin[1]), .maint_switch_on_i(pin[0]), .pout_data_i(pd), .dout_i(dout),
        .drive_alive_i(alive), .drive_stat1_i(stat1), .hw_err_detail_i(detail),
        .read_system_error_cmd_i(rd_cmd), .pout_data_o(pout), .dout_o(dout_q),
        .pin_stat1_o(pstat), .drive_inhibit_o(inh), .sys_err_rd_o(sysrd),
        .periph_fault_o(pf), .leds_o(leds));
    fsm_drive_model #(.N_DRIVES(4), .STOP_CYC(20)) drv (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .answer_i(answer),
        .drive_alive_o(alive), .drive_stat1_o(stat1), .stopped_o(stop));

    // ****
    // tasks
    // ****
    task chk(input logic [191:0] seen, input logic [191:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // pready is waited for, not assumed, although the slave answers at once
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk_i);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge ref_clk_i);
        penable <= 1'b1;
        // pready high ends this wait; the watchdog ends it only if pready never comes
        do begin
            @(posedge ref_clk_i);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task settle;
        repeat (8) @(posedge ref_clk_i);
    endtask
    task setpin(input int b, input logic v);
        @(posedge ref_clk_i);
        pin[b] <= v;
        settle();
    endtask
    // two whole blink periods: steady on gives 16, flashing exactly half
    task cnt(input int b);
        c = 0;
        repeat (16) begin
            @(posedge ref_clk_i);
            c += (leds[b] === 1'b1);
        end
    endtask
    function automatic logic [63:0] st(input logic [3:0] dead);
        for (int g = 0; g < 4; g++) st[g*16+:16] = dead[g] ? SYS_ERR_CODE : 16'h0a00 + 16'(g);
    endfunction
    task conclude;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // ****
    // tests
    // ****
    initial forever #5 ref_clk_i = ~ref_clk_i;
    initial begin
        #300000;
        n_errors++;
        $display("[FAIL] %0t watchdog expired", $time);
        conclude();
    end
    initial begin
        repeat (10) @(posedge ref_clk_i);
        nrst_i <= 1'b1;
        apb(1'b0, REG_CTRL, 32'h0);
        chk(rd, CTRL_RESET);
        apb(1'b0, 8'hfc, 32'h0);
        chk({err, rd}, 33'h1_0000_0000);
        apb(1'b1, REG_CTRL, 32'h0000_0006);
        apb(1'b0, REG_CTRL, 32'h0);
        chk(rd, 32'h0000_0006);
        $display("test registers done");
        foreach (pb[i]) begin
            setpin(pb[i], 1'b1);
            chk(leds[lb[i]], 1'b1);
            setpin(pb[i], 1'b0);
            chk(leds[lb[i]], 1'b0);
        end
        setpin(7, 1'b1);
        setpin(6, 1'b1);
        cnt(3);
        chk(c, 16);
        setpin(6, 1'b0);
        cnt(3);
        chk(c, 8);
        setpin(7, 1'b0);
        cnt(3);
        chk(c, 0);
        $display("test indicators done");
        // maintenance switch still off: no drive data, led steady
        cnt(0);
        chk(c, 16);
        setpin(0, 1'b1);
        cnt(0);
        chk(c, 0);
        chk(pstat, st(4'h0));
        @(posedge ref_clk_i);
        answer <= 4'he;
        settle();
        cnt(0);
        chk(c, 8);
        chk(pstat, st(4'h1));
        chk(stop, 4'h1);
        answer <= 4'hf;
        settle();
        chk(pstat, st(4'h0));
        answer <= 4'h0;
        settle();
        cnt(0);
        chk(c, 16);
        chk(stop, 4'hf);
        answer <= 4'hf;
        apb(1'b1, REG_CTRL, 32'h0000_0004);
        settle();
        cnt(0);
        chk(c, 16);
        $display("test drive link done");
        apb(1'b1, REG_CTRL, 32'h0000_0006);
        pd <= P3;
        dout <= 8'ha5;
        settle();
        chk(pout, P3);
        chk(dout_q, 8'ha5);
        setpin(3, 1'b1);
        chk(pout, '0);
        chk(dout_q, 8'h00);
        setpin(3, 1'b0);
        chk(pout, P3);
        chk(dout_q, 8'ha5);
        apb(1'b1, REG_CTRL, 32'h0000_0007);
        setpin(3, 1'b1);
        chk(pout, P3);
        chk(dout_q, 8'ha5);
        apb(1'b1, REG_CTRL, 32'h0000_0003);
        settle();
        chk(pout, P2);
        chk(dout_q, 8'ha5);
        setpin(3, 1'b0);
        $display("test fieldbus timeout done");
        apb(1'b1, REG_CTRL, 32'h0000_0006);
        detail <= 8'h42;
        setpin(0, 1'b0);
        setpin(2, 1'b1);
        chk(inh, 4'hf);
        chk(pstat, {4{SYS_ERR_CODE}});
        cnt(0);
        chk(c, 8);
        apb(1'b0, REG_ERRCODE, 32'h0);
        chk(rd[7:0], 8'h42);
        rd_cmd <= 1'b1;
        @(posedge ref_clk_i);
        rd_cmd <= 1'b0;
        settle();
        chk(sysrd, 8'h42);
        setpin(2, 1'b0);
        chk(inh, 4'h0);
        $display("test hardware defect done");
        setpin(1, 1'b1);
        chk(pf, 1'b1);
        chk(pstat, {4{SHORT_OUT_CODE}});
        apb(1'b0, REG_STATUS, 32'h0);
        chk(rd[6], 1'b1);
        setpin(1, 1'b0);
        chk(pf, 1'b1);
        apb(1'b1, REG_PFACK, 32'h0000_0001);
        settle();
        chk(pf, 1'b0);
        $display("test peripheral fault done");
        conclude();
    end
endmodule
